// ### verilog/acr_pkg.sv
// Purpose: Shared constants for the converter control and result block
// Assumes: Avalon-MM byte addressing, one 8-bit register per 32-bit word
// Notes: Offsets are byte addresses
package acr_pkg;
  localparam logic [4:0] ACR_OFF_SELECT = 5'h00;
  localparam logic [4:0] ACR_OFF_CTRL = 5'h04;
  localparam logic [4:0] ACR_OFF_RES_LO = 5'h08;
  localparam logic [4:0] ACR_OFF_RES_HI = 5'h0c;
  localparam logic [4:0] ACR_OFF_IRQ_STAT = 5'h10;
  localparam logic [4:0] ACR_OFF_IRQ_MASK = 5'h14;
  localparam logic [4:0] ACR_OFF_ACTIVE = 5'h18;
  // Select register fields
  localparam int ACR_REF_HI = 7;
  localparam int ACR_REF_LO = 6;
  localparam int ACR_LEFT_BIT = 5;
  localparam int ACR_CHAN_HI = 4;
  // Control/status fields
  localparam int ACR_ON_BIT = 7;
  localparam int ACR_BEGIN_BIT = 6;
  localparam int ACR_AUTO_BIT = 5;
  localparam int ACR_DONE_BIT = 4;
  localparam int ACR_IE_BIT = 3;
  localparam int ACR_DIV_HI = 2;
  localparam logic [7:0] ACR_SELECT_RST = 8'h00;
  localparam logic [7:0] ACR_CTRL_RST = 8'h00;
  // Conversion lengths in converter clocks
  localparam int ACR_FIRST_CLKS = 25;
  localparam int ACR_NORMAL_CLKS = 13;
  // Interrupt status bits
  localparam int ACR_EV_DONE = 0;
  localparam int ACR_EV_ABORT = 1;
  typedef enum logic [2:0] {
    ACR_IDLE = 3'b001,
    ACR_CONV = 3'b010,
    ACR_DONE = 3'b100
  } acr_state_t;
endpackage

// ### verilog/acr_clk_div.sv
// Purpose: Converter clock tick generator from the divider choice
// Assumes: Runs only while the converter is on
// Notes: Factor 2,2,4,8..128 per three-bit choice
`timescale 1ns/10ps
module acr_clk_div
  import acr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] div_choice_i,
  output logic tick_o
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  wire [6:0] limit;
  assign limit = (div_choice_i == 3'h0) ? 7'h01
               : 7'((8'h01 << div_choice_i) - 8'h01);
  assign cnt_d = (!run_i || cnt_q >= limit) ? 7'h00 : cnt_q + 7'h01;
  assign tick_o = run_i && (cnt_q >= limit);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) cnt_q <= 7'h00;
    else cnt_q <= cnt_d;
  end
endmodule

// ### verilog/acr_result_fmt.sv
// Purpose: Justifies the held 10-bit result into the 16-bit pair
// Assumes: Result word is already in final encoding
// Notes: Pure combinational, follows the justify bit at once
`timescale 1ns/10ps
module acr_result_fmt
  import acr_pkg::*;
(
  input wire logic [9:0] result_i,
  input wire logic left_i,
  output logic [15:0] pair_o
);
  assign pair_o = left_i ? {result_i, 6'h00} : {6'h00, result_i};
endmodule

// ### verilog/acr_top.sv
// Purpose: Converter control, channel select and result formatting
// Assumes: Analog core returns a sample when asked; Avalon-MM slave
// Notes: Summary of operation below
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/10ps
module acr_top
  import acr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic [9:0] sample_i,
  input wire logic auto_trigger_i,
  input wire logic vector_ack_i,
  output logic [1:0] reference_choice_o,
  output logic [4:0] channel_gain_choice_o,
  output logic differential_o,
  output logic sample_req_o,
  output logic converter_on_o,
  output logic done_irq_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] select_q;
  logic [7:0] ctrl_q;
  logic [1:0] ref_act_q;
  logic [4:0] chan_act_q;
  logic [9:0] result_q;
  logic lo_lock_q;
  logic first_q;
  logic [4:0] cyc_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic trig_q;
  acr_state_t state_q;
  acr_state_t state_d;
  logic tick;
  logic [15:0] pair;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  wire req = (avs_read_i | avs_write_i) & ~ack_q;
  // Writes land at the edge where waitrequest is seen low
  wire wr = avs_write_i & ack_q & avs_byteenable_i[0];
  wire rd = avs_read_i & ~ack_q;
  wire wr_sel = wr && avs_address_i == ACR_OFF_SELECT;
  wire wr_ctrl = wr && avs_address_i == ACR_OFF_CTRL;
  wire wr_mask = wr && avs_address_i == ACR_OFF_IRQ_MASK;
  wire rd_lo = rd && avs_address_i == ACR_OFF_RES_LO;
  wire rd_hi = rd && avs_address_i == ACR_OFF_RES_HI;
  wire rd_stat = rd && avs_address_i == ACR_OFF_IRQ_STAT;
  wire mapped = avs_address_i == ACR_OFF_SELECT
             || avs_address_i == ACR_OFF_CTRL
             || avs_address_i == ACR_OFF_RES_LO
             || avs_address_i == ACR_OFF_RES_HI
             || avs_address_i == ACR_OFF_IRQ_STAT
             || avs_address_i == ACR_OFF_IRQ_MASK
             || avs_address_i == ACR_OFF_ACTIVE;
  wire [7:0] wd = avs_writedata_i[7:0];
  assign avs_waitrequest_o = req;
  assign avs_response_o = 2'b00;
  assign avs_readdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////
  // Conversion control
  wire on = ctrl_q[ACR_ON_BIT];
  wire busy = state_q == ACR_CONV;
  wire turn_off = wr_ctrl && !wd[ACR_ON_BIT];
  wire on_next = wr_ctrl ? wd[ACR_ON_BIT] : on;
  wire trig_edge = auto_trigger_i & ~trig_q & ctrl_q[ACR_AUTO_BIT];
  wire start = on_next && !busy && !turn_off
            && ((wr_ctrl && wd[ACR_BEGIN_BIT]) || trig_edge);
  wire [4:0] conv_len = first_q ? 5'(ACR_FIRST_CLKS)
                                : 5'(ACR_NORMAL_CLKS);
  wire last = busy && tick && cyc_q == conv_len - 5'h01;
  wire finish = last && !turn_off;
  // hold the pair while a low-byte read awaits its high byte
  wire store = finish && !lo_lock_q;
  wire abort = busy && turn_off;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ACR_IDLE: if (start) state_d = ACR_CONV;
      ACR_CONV: if (abort || !on) state_d = ACR_IDLE;
        else if (last) state_d = ACR_DONE;
      ACR_DONE: state_d = ACR_IDLE;
      default: state_d = ACR_IDLE;
    endcase
  end

  acr_clk_div u_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(busy),
    .div_choice_i(ctrl_q[ACR_DIV_HI:0]),
    .tick_o(tick)
  );

  acr_result_fmt u_fmt (
    .result_i(result_q),
    .left_i(select_q[ACR_LEFT_BIT]),
    .pair_o(pair)
  );

  // gain and unity pair codes are differential
  wire diff = chan_act_q[4:3] != 2'b00 && chan_act_q[4:1] != 4'b1111;
  assign differential_o = diff;
  assign reference_choice_o = ref_act_q;
  assign channel_gain_choice_o = chan_act_q;
  assign sample_req_o = last;
  assign converter_on_o = on;
  assign done_irq_o = ctrl_q[ACR_DONE_BIT] & ctrl_q[ACR_IE_BIT];
  assign irq_o = |(stat_q & mask_q);

  wire [7:0] ctrl_rd = {ctrl_q[7], busy, ctrl_q[5:0]};
  wire [7:0] rd_mux = avs_address_i == ACR_OFF_SELECT ? select_q
    : avs_address_i == ACR_OFF_CTRL ? ctrl_rd
    : avs_address_i == ACR_OFF_RES_LO ? pair[7:0]
    : avs_address_i == ACR_OFF_RES_HI ? pair[15:8]
    : avs_address_i == ACR_OFF_IRQ_STAT ? {6'h00, stat_q}
    : avs_address_i == ACR_OFF_IRQ_MASK ? {6'h00, mask_q}
    : {7'h00, busy};
  wire done_clr = (wr_ctrl && wd[ACR_DONE_BIT]) || vector_ack_i;
  wire [1:0] ev = {abort, store};
  wire [7:0] ctrl_wr = {wd[7], 1'b0, wd[5], 1'b0, wd[3:0]};
  wire done_next = store | (ctrl_q[ACR_DONE_BIT] & ~done_clr);

  ////////////////////////////////////////////////////////////////////
  // Sequential
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      select_q <= ACR_SELECT_RST;
      ctrl_q <= ACR_CTRL_RST;
      ref_act_q <= 2'h0;
      chan_act_q <= 5'h00;
      result_q <= 10'h000;
      lo_lock_q <= 1'b0;
      first_q <= 1'b1;
      cyc_q <= 5'h00;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      trig_q <= 1'b0;
      state_q <= ACR_IDLE;
    end else begin
      state_q <= state_d;
      trig_q <= auto_trigger_i;
      ack_q <= req;
      if (rd) rdata_q <= mapped ? {24'h0, rd_mux} : 32'h0000_0000;
      if (wr_sel) select_q <= wd;
      if (wr_ctrl) ctrl_q <= {ctrl_wr[7:5], done_next, ctrl_wr[3:0]};
      else ctrl_q[ACR_DONE_BIT] <= done_next;
      if (wr_mask) mask_q <= wd[1:0];
      // Set wins over read clear
      stat_q <= (rd_stat ? 2'h0 : stat_q) | ev;
      // active selections follow only when idle or at completion
      if (!busy || last) begin
        ref_act_q <= wr_sel ? wd[ACR_REF_HI:ACR_REF_LO]
                            : select_q[ACR_REF_HI:ACR_REF_LO];
        chan_act_q <= wr_sel ? wd[ACR_CHAN_HI:0]
                             : select_q[ACR_CHAN_HI:0];
      end
      if (store) result_q <= sample_i;
      if (rd_lo) lo_lock_q <= 1'b1;
      else if (rd_hi) lo_lock_q <= 1'b0;
      if (!on_next) first_q <= 1'b1;
      else if (finish) first_q <= 1'b0;
      if (!busy || tick && last) cyc_q <= 5'h00;
      else if (tick) cyc_q <= cyc_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  done_sets_a: assert property (@(posedge clock_i) disable iff (rst_i)
    store |=> ctrl_q[ACR_DONE_BIT])
    else $error("done flag not set on store");
  result_loads_a: assert property (@(posedge clock_i) disable iff (rst_i)
    store |=> result_q == $past(sample_i))
    else $error("result not stored");
  result_holds_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(store) |-> $stable(result_q))
    else $error("result changed without completion");
  lock_holds_a: assert property (@(posedge clock_i) disable iff (rst_i)
    lo_lock_q && !rd_hi |=> $stable(result_q))
    else $error("result updated while locked");
  justify_now_a: assert property (@(posedge clock_i) disable iff (rst_i)
    select_q[ACR_LEFT_BIT] |-> pair[5:0] == 6'h00
      && pair[15:6] == result_q)
    else $error("left justify wrong");
  right_just_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !select_q[ACR_LEFT_BIT] |-> pair[15:10] == 6'h00)
    else $error("right justify wrong");
  defer_sel_a: assert property (@(posedge clock_i) disable iff (rst_i)
    busy && !last |=> $stable(chan_act_q) && $stable(ref_act_q))
    else $error("selection changed mid conversion");
  abort_stop_a: assert property (@(posedge clock_i) disable iff (rst_i)
    abort |=> state_q == ACR_IDLE && stat_q[ACR_EV_ABORT])
    else $error("abort did not stop conversion");
  busy_reads_a: assert property (@(posedge clock_i) disable iff (rst_i)
    start |=> busy [*2])
    else $error("begin bit not held");
  first_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
    busy && tick && first_q && cyc_q == 5'd24 |-> last)
    else $error("first conversion length wrong");
  done_cov_c: cover property (@(posedge clock_i) store);
  abort_cov_c: cover property (@(posedge clock_i) abort);
  lock_cov_c: cover property (@(posedge clock_i) finish && lo_lock_q);
endmodule

// ### test/acr_top_tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: One wait cycle per bus access, divider choice 0 (factor 2)
// Notes: Analog core is stood in for by sample_i
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module acr_top_tb;
  import acr_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o;
  logic [9:0] sample_i = 10'h000;
  logic auto_trigger_i = 1'b0;
  logic vector_ack_i = 1'b0;
  logic [1:0] reference_choice_o;
  logic [4:0] channel_gain_choice_o;
  logic differential_o, sample_req_o, converter_on_o, done_irq_o, irq_o;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0 = 0;
  logic [7:0] q;

  acr_top u_acr_top (.clock_i(clock_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .sample_i(sample_i), .auto_trigger_i(auto_trigger_i),
    .vector_ack_i(vector_ack_i), .reference_choice_o(reference_choice_o),
    .channel_gain_choice_o(channel_gain_choice_o),
    .differential_o(differential_o), .sample_req_o(sample_req_o),
    .converter_on_o(converter_on_o), .done_irq_o(done_irq_o),
    .irq_o(irq_o));

  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= {24'h000000, d};
    do begin
      @(posedge clock_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 100);
    q = avs_readdata_o[7:0];
    `CHK(avs_waitrequest_o, 1'b0)
    `CHK(avs_response_o, 2'b00)
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    t0 = cyc;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask

  // Waits for the sampling cycle and checks the conversion length
  task automatic conv(input int lo, input int hi);
    int k;
    k = 0;
    while (sample_req_o !== 1'b1 && k < 1000) begin
      @(posedge clock_i);
      k++;
    end
    `CHK((cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1)
    @(posedge clock_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    stop_test;
  end

  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rdc(ACR_OFF_SELECT, 8'h00);
    rdc(ACR_OFF_CTRL, 8'h00);
    rdc(5'h1c, 8'h00);
    for (int c = 0; c < 32; c++) begin
      wr(ACR_OFF_SELECT, {c[1:0], 1'b0, c[4:0]});
      `CHK(channel_gain_choice_o, c[4:0])
      `CHK(reference_choice_o, c[1:0])
      `CHK(differential_o, (c >= 8 && c <= 29))
    end
    wr(ACR_OFF_IRQ_MASK, 8'h01);
    rdc(ACR_OFF_IRQ_MASK, 8'h01);
    // Differential pair, gain 10, internal reference, left justified
    wr(ACR_OFF_SELECT, 8'hed);
    sample_i <= 10'h270;
    wr(ACR_OFF_CTRL, 8'hc0);
    rdc(ACR_OFF_CTRL, 8'hc0);
    rdc(ACR_OFF_ACTIVE, 8'h01);
    wr(ACR_OFF_SELECT, 8'h01);
    `CHK(channel_gain_choice_o, 5'h0d)
    `CHK(reference_choice_o, 2'b11)
    conv(40, 56);
    `CHK(channel_gain_choice_o, 5'h01)
    `CHK(reference_choice_o, 2'b00)
    `CHK(irq_o, 1'b1)
    `CHK(done_irq_o, 1'b0)
    rdc(ACR_OFF_CTRL, 8'h90);
    rdc(ACR_OFF_RES_LO, 8'h70);
    rdc(ACR_OFF_RES_HI, 8'h02);
    wr(ACR_OFF_SELECT, 8'h21);
    rdc(ACR_OFF_RES_LO, 8'h00);
    rdc(ACR_OFF_RES_HI, 8'h9c);
    rdc(ACR_OFF_IRQ_STAT, 8'h01);
    rdc(ACR_OFF_IRQ_STAT, 8'h00);
    `CHK(irq_o, 1'b0)
    wr(ACR_OFF_CTRL, 8'h90);
    rdc(ACR_OFF_CTRL, 8'h80);
    // Single-ended full scale, right justified, later conversion
    wr(ACR_OFF_SELECT, 8'h01);
    sample_i <= 10'h3ff;
    wr(ACR_OFF_CTRL, 8'hc8);
    conv(18, 30);
    `CHK(done_irq_o, 1'b1)
    vector_ack_i <= 1'b1;
    @(posedge clock_i);
    vector_ack_i <= 1'b0;
    @(posedge clock_i);
    `CHK(done_irq_o, 1'b0)
    rdc(ACR_OFF_RES_LO, 8'hff);
    // Low byte read locks the pair against the next completion
    sample_i <= 10'h000;
    wr(ACR_OFF_CTRL, 8'hc8);
    conv(18, 30);
    rdc(ACR_OFF_CTRL, 8'h88);
    rdc(ACR_OFF_RES_HI, 8'h03);
    rdc(ACR_OFF_RES_LO, 8'hff);
    rdc(ACR_OFF_RES_HI, 8'h03);
    rdc(ACR_OFF_IRQ_STAT, 8'h01);
    // Switching off in mid-conversion
    wr(ACR_OFF_CTRL, 8'hc0);
    wr(ACR_OFF_CTRL, 8'h00);
    `CHK(converter_on_o, 1'b0)
    rdc(ACR_OFF_ACTIVE, 8'h00);
    rdc(ACR_OFF_IRQ_STAT, 8'h02);
    repeat (60) @(posedge clock_i);
    rdc(ACR_OFF_CTRL, 8'h00);
    // Auto trigger edge starts a first-length conversion
    wr(ACR_OFF_CTRL, 8'ha0);
    auto_trigger_i <= 1'b1;
    @(posedge clock_i);
    auto_trigger_i <= 1'b0;
    conv(44, 60);
    rdc(ACR_OFF_CTRL, 8'hb0);
    stop_test;
  end
endmodule
